// [logic/hwo_pkg.sv]
`default_nettype none
package hwo_pkg;
  // Clock rates. The crystal rate is a plain default; the crystal tick is derived from it.
  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned CRYSTAL_HZ        = 4_000_000;
  localparam int unsigned CRYSTAL_DIV       = CLK_HZ / CRYSTAL_HZ;

  // Register indices and their byte addresses on the 32-bit bus.
  localparam logic [7:0]  OPT_A_INDEX       = 8'h1F;
  localparam logic [7:0]  OPT_B_INDEX       = 8'h20;
  localparam logic [7:0]  OPT_A_ADDR        = 8'h7C;
  localparam logic [7:0]  OPT_B_ADDR        = 8'h80;

  // Field positions in the first option register.
  localparam int unsigned UV_HALT_BIT       = 7;
  localparam int unsigned ROM_PROTECT_BIT   = 6;
  localparam int unsigned UV_RST_DIS_BIT    = 5;
  localparam int unsigned UV_PWR_DIS_BIT    = 4;
  localparam int unsigned SHORT_REC_BIT     = 3;
  localparam int unsigned WDOG_RATE_BIT     = 2;
  localparam int unsigned HALT_ALLOW_BIT    = 1;
  localparam int unsigned WDOG_DIS_BIT      = 0;
  // Field position in the second option register.
  localparam int unsigned EE_PROTECT_BIT    = 0;

  // Fixed option values of this part.
  localparam logic [7:0]  OPT_A_VALUE       = 8'h86;
  localparam logic [7:0]  OPT_B_VALUE       = 8'h01;

  // Timeout lengths in crystal clock cycles.
  localparam int unsigned REC_SHORT_CYCLES  = 32;
  localparam int unsigned REC_LONG_CYCLES   = 4096;
  localparam int unsigned WDOG_LONG_CYCLES  = (1 << 18) - (1 << 4);
  localparam int unsigned WDOG_SHORT_CYCLES = (1 << 13) - (1 << 4);
  localparam int unsigned TMO_WIDTH         = 19;

  // Protected EEPROM window.
  localparam logic [15:0] EE_PROT_LO        = 16'h08F0;
  localparam logic [15:0] EE_PROT_HI        = 16'h08FF;
endpackage
`default_nettype wire

// [logic/hwo_timeout.sv]
`timescale 1ns/1ns
`default_nettype none
module hwo_timeout #(
  parameter int unsigned WIDTH = 19
) (
  // Clock and reset.
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  // Control.
  input  wire logic             tick_in,
  input  wire logic             start_in,
  input  wire logic             run_in,
  input  wire logic [WIDTH-1:0] limit_in,
  // Status.
  output logic                  busy_out,
  output logic                  expire_out
);
  // Refuse a counter width that the comparison logic cannot serve.
  if (WIDTH < 2 || WIDTH > 31)
  begin : g_bad_width
    $error("hwo_timeout: WIDTH out of range");
  end

  // Tick counter of the current interval.
  logic [WIDTH-1:0] count;

  // Count ticks while running; start always restarts from zero.
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      count      <= '0;
      busy_out   <= 1'b0;
      expire_out <= 1'b0;
    end
    else
    begin
      expire_out <= 1'b0;
      if (start_in)
      begin
        // A restart wins over a tick in the same cycle.
        count    <= '0;
        busy_out <= 1'b1;
      end
      else if (busy_out && run_in && tick_in)
      begin
        if (count == limit_in - 1'b1)
        begin
          busy_out   <= 1'b0;
          expire_out <= 1'b1;
        end
        else
        begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [logic/hwo_option_regs.sv]
// Function
// R1: First option register fixed, reset-proof, read-only.
// R2: Monitor runs in halt only if enabled.
// R3: ROM protect bit denies ROM access.
// R4: Reset-disable bit blocks monitor resets.
// R5: Power-disable bit removes monitor power.
// R6: Halt recovery lasts 32 or 4096 ticks.
// R7: Keep short recovery clear with crystal oscillator.
// R8: Watchdog timeout long or short by rate.
// R9: Halt opcode executes or is illegal.
// R10: Watchdog disable bit turns watchdog off.
// R11: EEPROM protect blocks window and config writes.
// R12: Fixed values match this part's option set.
// R13: Second option register fixed and read-only.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module hwo_option_regs
  import hwo_pkg::*;
#(
  parameter int unsigned XTAL_DIV   = hwo_pkg::CRYSTAL_DIV,
  parameter int unsigned WDOG_LONG  = hwo_pkg::WDOG_LONG_CYCLES,
  parameter int unsigned WDOG_SHORT = hwo_pkg::WDOG_SHORT_CYCLES,
  parameter int unsigned REC_LONG   = hwo_pkg::REC_LONG_CYCLES,
  parameter int unsigned REC_SHORT  = hwo_pkg::REC_SHORT_CYCLES
) (
  // Clock and reset.
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Undervolt monitor.
  input  wire logic        undervolt_detect_in,
  input  wire logic        halt_mode_in,
  output logic             undervolt_monitor_enable_out,
  output logic             undervolt_power_out,
  output logic             undervolt_reset_out,
  // ROM access gate.
  input  wire logic        rom_access_req_in,
  output logic             rom_access_grant_out,
  // EEPROM program and erase gate.
  input  wire logic        eeprom_pe_req_in,
  input  wire logic [15:0] eeprom_pe_addr_in,
  input  wire logic        eeprom_cfg_sel_in,
  output logic             eeprom_pe_grant_out,
  // Halt instruction and recovery.
  input  wire logic        halt_opcode_in,
  input  wire logic        halt_exit_req_in,
  output logic             halt_exec_out,
  output logic             illegal_opcode_out,
  output logic             halt_recovered_out,
  // Watchdog timer.
  input  wire logic        watchdog_clear_in,
  output logic             watchdog_enable_out,
  output logic             watchdog_reset_out
);
  import hwo_pkg::*;

  // Refuse counts that the timeout counter cannot hold.
  if (WDOG_LONG >= (1 << TMO_WIDTH) || REC_LONG >= (1 << TMO_WIDTH) || WDOG_SHORT == 0 ||
      WDOG_SHORT >= (1 << TMO_WIDTH) || REC_SHORT >= (1 << TMO_WIDTH) ||
      REC_SHORT == 0 || XTAL_DIV < 2 || XTAL_DIV > 65536)
  begin : g_bad_param
    $error("hwo_option_regs: timeout or divider parameter out of range");
  end

  // Option bits are wired constants, so neither reset nor writes can touch them.
  wire logic [7:0] opt_a = OPT_A_VALUE; // see R1 see R12
  wire logic [7:0] opt_b = OPT_B_VALUE; // see R13 see R12

  // Individual option bits, named after what they steer.
  wire logic uv_in_halt   = opt_a[UV_HALT_BIT];
  wire logic rom_protect  = opt_a[ROM_PROTECT_BIT];
  wire logic uv_rst_dis   = opt_a[UV_RST_DIS_BIT];
  wire logic uv_pwr_dis   = opt_a[UV_PWR_DIS_BIT];
  wire logic short_rec    = opt_a[SHORT_REC_BIT];
  wire logic wdog_rate    = opt_a[WDOG_RATE_BIT];
  wire logic halt_allow   = opt_a[HALT_ALLOW_BIT];
  wire logic wdog_dis     = opt_a[WDOG_DIS_BIT];
  wire logic ee_protect   = opt_b[EE_PROTECT_BIT];

  // Bus acknowledge: one wait cycle, then the answer.
  logic ack;

  // The request is held with waitrequest high for one cycle, so read data is registered.
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= (avs_read_in || avs_write_in) && !ack;
    end
  end

  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;

  // Read data; writes are accepted and dropped, unmapped reads answer zero.
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      avs_readdata_out <= 32'h00000000;
    end
    else if (avs_read_in && !ack)
    begin
      case (avs_address_in)
        OPT_A_ADDR: avs_readdata_out <= {24'h000000, opt_a}; // see R1
        OPT_B_ADDR: avs_readdata_out <= {24'h000000, opt_b}; // see R13
        default:    avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  // Crystal tick divider; all timeouts count these enable pulses.
  logic [15:0] div_count;
  logic        xtal_tick;

  // The divider free-runs from reset; the timeouts therefore may be short by one tick phase.
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      div_count <= 16'h0000;
      xtal_tick <= 1'b0;
    end
    else if (div_count == 16'(XTAL_DIV - 1))
    begin
      div_count <= 16'h0000;
      xtal_tick <= 1'b1;
    end
    else
    begin
      div_count <= div_count + 16'h0001;
      xtal_tick <= 1'b0;
    end
  end

  // Detector input comes from the analog comparator and is synchronised first.
  logic uv_sync_a;
  logic uv_sync_b;
  logic uv_seen;

  // Two-stage synchroniser and edge memory for the detector.
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      uv_sync_a <= 1'b0;
      uv_sync_b <= 1'b0;
      uv_seen   <= 1'b0;
    end
    else
    begin
      uv_sync_a <= undervolt_detect_in;
      uv_sync_b <= uv_sync_a;
      uv_seen   <= uv_sync_b;
    end
  end

  // Monitor power and activity follow the option bits and halt mode.
  assign undervolt_power_out          = !uv_pwr_dis; // see R5
  assign undervolt_monitor_enable_out = !uv_pwr_dis && (!halt_mode_in || uv_in_halt); // see R2

  // Monitor reset pulse on a rising detection, only if resets are allowed.
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      undervolt_reset_out <= 1'b0;
    end
    else
    begin
      undervolt_reset_out <= uv_sync_b && !uv_seen && !uv_rst_dis && // see R4
                             undervolt_monitor_enable_out;
    end
  end

  // The protected EEPROM targets: the top window and both configuration registers.
  wire logic ee_in_window = (eeprom_pe_addr_in >= EE_PROT_LO) && (eeprom_pe_addr_in <= EE_PROT_HI);

  // Access gates and halt opcode decode, registered one cycle after the request.
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      rom_access_grant_out <= 1'b0;
      eeprom_pe_grant_out  <= 1'b0;
      halt_exec_out        <= 1'b0;
      illegal_opcode_out   <= 1'b0;
    end
    else
    begin
      rom_access_grant_out <= rom_access_req_in && !rom_protect; // see R3
      eeprom_pe_grant_out  <= eeprom_pe_req_in && // see R11
                              !(ee_protect && (ee_in_window || eeprom_cfg_sel_in));
      halt_exec_out        <= halt_opcode_in && halt_allow; // see R9
      illegal_opcode_out   <= halt_opcode_in && !halt_allow; // see R9
    end
  end

  // Timeout lengths picked by the option bits.
  wire logic [TMO_WIDTH-1:0] rec_limit  = short_rec ? TMO_WIDTH'(REC_SHORT) :
                                                      TMO_WIDTH'(REC_LONG); // see R6
  wire logic [TMO_WIDTH-1:0] wdog_limit = wdog_rate ? TMO_WIDTH'(WDOG_LONG) :
                                                      TMO_WIDTH'(WDOG_SHORT); // see R8
  logic wdog_busy;
  wire logic wdog_start = watchdog_clear_in || (watchdog_enable_out && !wdog_busy);

  assign watchdog_enable_out = !wdog_dis; // see R10

  // Halt recovery delay; it starts when the exit request arrives.
  hwo_timeout #(
    .WIDTH      (TMO_WIDTH)
  ) u_rec_tmo (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (xtal_tick),
    .start_in   (halt_exit_req_in),
    .run_in     (1'b1),
    .limit_in   (rec_limit),
    .busy_out   (),
    .expire_out (halt_recovered_out)
  );

  // Watchdog interval; it freezes in halt and is held idle while disabled.
  logic wdog_expire;
  hwo_timeout #(
    .WIDTH      (TMO_WIDTH)
  ) u_wdog_tmo (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (xtal_tick),
    .start_in   (wdog_start && watchdog_enable_out),
    .run_in     (!halt_mode_in && watchdog_enable_out),
    .limit_in   (wdog_limit),
    .busy_out   (wdog_busy),
    .expire_out (wdog_expire)
  );

  assign watchdog_reset_out = wdog_expire && watchdog_enable_out; // see R10

  // Helper: ticks the watchdog interval has run since its last start.
  // It mirrors the freeze in halt so that a wrong length shows up in the check below.
  logic [TMO_WIDTH:0] wdog_ticks;
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || (wdog_start && watchdog_enable_out))
    begin
      wdog_ticks <= '0;
    end
    else if (xtal_tick && !halt_mode_in && watchdog_enable_out)
    begin
      wdog_ticks <= wdog_ticks + 1'b1;
    end
  end

  // Helper: ticks seen since the recovery delay started.
  logic [TMO_WIDTH:0] rec_ticks;
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || halt_exit_req_in)
    begin
      rec_ticks <= '0;
    end
    else if (xtal_tick)
    begin
      rec_ticks <= rec_ticks + 1'b1;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // Named sequences for the bus answer.
  sequence s_read_a;
    avs_read_in && !ack && avs_address_in == OPT_A_ADDR;
  endsequence
  sequence s_read_b;
    avs_read_in && !ack && avs_address_in == OPT_B_ADDR;
  endsequence

  a_opt_a_read: assert property (s_read_a ##1 !avs_waitrequest_out |-> // see R1
    avs_readdata_out == {24'h000000, OPT_A_VALUE}) else $error("option A read wrong");
  a_opt_b_read: assert property (s_read_b ##1 !avs_waitrequest_out |-> // see R13
    avs_readdata_out == {24'h000000, OPT_B_VALUE}) else $error("option B read wrong");
  a_write_no_change: assert property (avs_write_in |=> $stable(avs_readdata_out)) // see R1
    else $error("read data changed on write");
  a_uv_halt_gate: assert property (halt_mode_in && !uv_pwr_dis |-> // see R2
    undervolt_monitor_enable_out == uv_in_halt) else $error("monitor halt gating wrong");
  a_rom_gate: assert property (rom_access_req_in |=> rom_access_grant_out == !rom_protect) // see R3
    else $error("ROM gate wrong");
  a_uv_reset_gate: assert property (undervolt_reset_out |-> !uv_rst_dis && $past(uv_sync_b)) // see R4
    else $error("monitor reset while disabled");
  a_uv_power: assert property (undervolt_power_out != uv_pwr_dis) // see R5
    else $error("monitor power wrong");
  a_rec_length: assert property ($rose(halt_recovered_out) |-> // see R6
    rec_ticks == (OPT_A_VALUE[SHORT_REC_BIT] ? REC_SHORT : REC_LONG))
    else $error("halt recovery length wrong");
  a_wdog_limit: assert property ($rose(watchdog_reset_out) |-> // see R8
    wdog_ticks == (OPT_A_VALUE[WDOG_RATE_BIT] ? WDOG_LONG : WDOG_SHORT))
    else $error("watchdog interval length wrong");
  a_halt_decode: assert property (halt_opcode_in |=> halt_exec_out == halt_allow && // see R9
    illegal_opcode_out == !halt_allow) else $error("halt decode wrong");
  a_wdog_off: assert property (watchdog_enable_out == !OPT_A_VALUE[WDOG_DIS_BIT] && // see R10
    (watchdog_enable_out || !watchdog_reset_out)) else $error("watchdog enable wrong");
  a_ee_protect: assert property (eeprom_pe_req_in && ee_protect && // see R11
    (ee_in_window || eeprom_cfg_sel_in) |=> !eeprom_pe_grant_out) else $error("EEPROM not blocked");
endmodule
`default_nettype wire

// [testbench/hardwired_option_registers_tb.sv]
`timescale 1ns/1ns
`default_nettype none
// Compares a seen value with an expected one and counts both outcomes.
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) \
    begin \
      num_errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module hardwired_option_registers_tb;
  import hwo_pkg::*;
  // Shortened counts keep the run brief; every window below is derived from them.
  localparam int unsigned DIV = 4;
  localparam int unsigned WL  = 40;
  localparam int unsigned WS  = 20;
  localparam int unsigned RL  = 8;
  localparam int unsigned RS  = 4;
  // Fixed option set, bit 7 down to bit 0, and the second register's protect bit.
  localparam logic [31:0] EXP_A = {24'h000000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  localparam logic [31:0] EXP_B = 32'h00000001;

  logic        mclk_in;
  logic        sys_rst_in;
  logic [7:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        undervolt_detect_in;
  logic        halt_mode_in;
  logic        undervolt_monitor_enable_out;
  logic        undervolt_power_out;
  logic        undervolt_reset_out;
  logic        rom_access_req_in;
  logic        rom_access_grant_out;
  logic        eeprom_pe_req_in;
  logic [15:0] eeprom_pe_addr_in;
  logic        eeprom_cfg_sel_in;
  logic        eeprom_pe_grant_out;
  logic        halt_opcode_in;
  logic        halt_exit_req_in;
  logic        halt_exec_out;
  logic        illegal_opcode_out;
  logic        halt_recovered_out;
  logic        watchdog_clear_in;
  logic        watchdog_enable_out;
  logic        watchdog_reset_out;
  int          num_errors  = 0;
  int          comparisons = 0;
  int          n;
  int          hits;
  logic [31:0] seed = 32'h00004EF0;
  logic [31:0] r;
  logic        e_rom;
  logic        e_ee;
  logic        e_halt;
  // Addresses just outside and just inside the protected window.
  logic [15:0] corner [4] = '{16'h08EF, 16'h08F0, 16'h08FF, 16'h0900};

  hwo_option_regs #(
    .XTAL_DIV  (DIV),
    .WDOG_LONG (WL),
    .WDOG_SHORT(WS),
    .REC_LONG  (RL),
    .REC_SHORT (RS)
  ) DUT (
    .mclk_in                     (mclk_in),
    .sys_rst_in                  (sys_rst_in),
    .avs_address_in              (avs_address_in),
    .avs_read_in                 (avs_read_in),
    .avs_write_in                (avs_write_in),
    .avs_writedata_in            (avs_writedata_in),
    .avs_byteenable_in           (avs_byteenable_in),
    .avs_readdata_out            (avs_readdata_out),
    .avs_waitrequest_out         (avs_waitrequest_out),
    .undervolt_detect_in         (undervolt_detect_in),
    .halt_mode_in                (halt_mode_in),
    .undervolt_monitor_enable_out(undervolt_monitor_enable_out),
    .undervolt_power_out         (undervolt_power_out),
    .undervolt_reset_out         (undervolt_reset_out),
    .rom_access_req_in           (rom_access_req_in),
    .rom_access_grant_out        (rom_access_grant_out),
    .eeprom_pe_req_in            (eeprom_pe_req_in),
    .eeprom_pe_addr_in           (eeprom_pe_addr_in),
    .eeprom_cfg_sel_in           (eeprom_cfg_sel_in),
    .eeprom_pe_grant_out         (eeprom_pe_grant_out),
    .halt_opcode_in              (halt_opcode_in),
    .halt_exit_req_in            (halt_exit_req_in),
    .halt_exec_out               (halt_exec_out),
    .illegal_opcode_out          (illegal_opcode_out),
    .halt_recovered_out          (halt_recovered_out),
    .watchdog_clear_in           (watchdog_clear_in),
    .watchdog_enable_out         (watchdog_enable_out),
    .watchdog_reset_out          (watchdog_reset_out)
  );

  // Free-running 100 MHz clock.
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Repeatable xorshift source.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // A program or erase is granted only outside the window and off the config registers.
  function automatic logic exp_ee(logic req, logic [15:0] a, logic cfg);
    return req & ~(EXP_B[0] & (cfg | (a >= 16'h08F0 && a <= 16'h08FF)));
  endfunction

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One Avalon transfer; the request holds until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk_in);
    avs_read_in       <= ~wr;
    avs_write_in      <= wr;
    avs_address_in    <= a;
    avs_writedata_in  <= wd;
    avs_byteenable_in <= wd[3:0];
    n = 0;
    // Waitrequest and read data are both taken at the rising edge that ends the transfer.
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 50);
    rd = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
    `CHK("bus_answer", 1'b1, n < 50)
  endtask

  // Writes random words to both option registers, then reads back the fixed values.
  task automatic check_regs();
    logic [31:0] d;
    bus(1'b1, OPT_A_ADDR, xs(), d);
    bus(1'b1, OPT_B_ADDR, xs(), d);
    bus(1'b0, OPT_A_ADDR, 32'h00000000, d);
    `CHK("opt_a", EXP_A, d)
    `CHK("short_rec_clear", 1'b0, d[SHORT_REC_BIT])
    bus(1'b0, OPT_B_ADDR, 32'h00000000, d);
    `CHK("opt_b", EXP_B, d)
    bus(1'b0, 8'h84, 32'h00000000, d);
    `CHK("unmapped", 32'h00000000, d)
  endtask

  // Counts cycles until the chosen pulse shows, bounded.
  task automatic wait_pulse(input logic wd);
    n = 0;
    do
    begin
      @(negedge mclk_in);
      n++;
    end
    while ((wd ? watchdog_reset_out : halt_recovered_out) !== 1'b1 && n < 1000);
  endtask

  // A hang counts as a mismatch and ends the run through the same closing task.
  initial
  begin
    #100000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    sys_rst_in = 1'b1;
    {avs_read_in, avs_write_in, undervolt_detect_in, halt_mode_in} = 4'h0;
    {rom_access_req_in, eeprom_pe_req_in, eeprom_cfg_sel_in} = 3'h0;
    {halt_opcode_in, halt_exit_req_in, watchdog_clear_in} = 3'h0;
    avs_address_in    = 8'h00;
    avs_writedata_in  = 32'h00000000;
    avs_byteenable_in = 4'h0;
    eeprom_pe_addr_in = 16'h0000;
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    check_regs();
    // Random gate traffic; registered answers are checked one cycle later.
    for (int i = 0; i < 60; i++)
    begin
      @(posedge mclk_in);
      r = xs();
      rom_access_req_in <= r[0];
      eeprom_pe_req_in  <= r[1];
      eeprom_cfg_sel_in <= r[2] & r[3];
      eeprom_pe_addr_in <= r[4] ? corner[r[6:5]] : r[31:16];
      halt_opcode_in    <= r[7];
      halt_mode_in      <= r[8];
      @(negedge mclk_in);
      if (i > 0)
      begin
        `CHK("rom_grant", e_rom, rom_access_grant_out)
        `CHK("ee_grant", e_ee, eeprom_pe_grant_out)
        `CHK("halt_exec", e_halt & EXP_A[1], halt_exec_out)
        `CHK("illegal", e_halt & ~EXP_A[1], illegal_opcode_out)
      end
      e_rom  = rom_access_req_in & ~EXP_A[6];
      e_ee   = exp_ee(eeprom_pe_req_in, eeprom_pe_addr_in, eeprom_cfg_sel_in);
      e_halt = halt_opcode_in;
      `CHK("uv_enable", ~halt_mode_in | EXP_A[7], undervolt_monitor_enable_out)
      `CHK("uv_power", ~EXP_A[4], undervolt_power_out)
      `CHK("wd_enable", ~EXP_A[0], watchdog_enable_out)
    end
    @(posedge mclk_in);
    {rom_access_req_in, eeprom_pe_req_in, halt_opcode_in, halt_mode_in} <= 4'h0;
    // A detected undervolt must produce exactly one reset pulse.
    undervolt_detect_in <= 1'b1;
    hits = 0;
    repeat (8)
    begin
      @(negedge mclk_in);
      hits += (undervolt_reset_out === 1'b1);
    end
    `CHK("uv_reset_pulses", 1, hits)
    @(posedge mclk_in);
    undervolt_detect_in <= 1'b0;
    // Leaving halt takes the long recovery, which a short setting could not reach.
    halt_mode_in     <= 1'b1;
    halt_exit_req_in <= 1'b1;
    @(posedge mclk_in);
    halt_exit_req_in <= 1'b0;
    wait_pulse(1'b0);
    `CHK("rec_window", 1'b1, n >= (RL - 1) * DIV && n <= RL * DIV + 3)
    @(negedge mclk_in);
    `CHK("rec_width", 1'b0, halt_recovered_out)
    // A cleared watchdog must run the long interval before it bites.
    @(posedge mclk_in);
    halt_mode_in      <= 1'b0;
    watchdog_clear_in <= 1'b1;
    @(posedge mclk_in);
    watchdog_clear_in <= 1'b0;
    wait_pulse(1'b1);
    `CHK("wd_window", 1'b1, n >= (WL - 1) * DIV && n <= WL * DIV + 4)
    @(negedge mclk_in);
    `CHK("wd_width", 1'b0, watchdog_reset_out)
    // A reset in mid-run must leave both option registers as they were.
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    check_regs();
    tally_and_finish();
  end
endmodule
`default_nettype wire
